// *** rtl/lhj_judge.sv ***
// Load and displacement hold judgment with hysteresis, inflection trigger and many-point hold
`timescale 1ns/100ps
`default_nettype none
module lhj_judge #(
  parameter int W           = 24,
  parameter int TICK_CYCLES = lhj_pkg::TICK_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic                         meas_start,
  input  wire logic signed [W-1:0]          meas_load,
  input  wire logic signed [W-1:0]          meas_disp,
  input  wire lhj_pkg::lhj_mode_t           hold_mode,
  input  wire lhj_pkg::lhj_crit_t           criterion,
  input  wire logic [lhj_pkg::TICK_W-1:0]   meas_time,
  input  wire logic signed [W-1:0]          upper_limit,
  input  wire logic signed [W-1:0]          lower_limit,
  input  wire logic signed [W-1:0]          upper_upper_limit,
  input  wire logic signed [W-1:0]          lower_lower_limit,
  input  wire logic                         upper_upper_enable,
  input  wire logic                         lower_lower_enable,
  input  wire logic signed [W-1:0]          hysteresis_width,
  input  wire logic                         continuous_judgment,
  input  wire logic signed [W-1:0]          disp_upper_limit,
  input  wire logic signed [W-1:0]          disp_lower_limit,
  input  wire logic [lhj_pkg::ANA_W-1:0]    analysis_offset,
  input  wire logic [lhj_pkg::ANA_W-1:0]    peak_range,
  input  wire logic [lhj_pkg::ANA_W-1:0]    peak_inhibit,
  input  wire logic [lhj_pkg::ANA_W-1:0]    inflection_shift,
  input  wire logic signed [W-1:0]          analysis_start_level,
  input  wire logic signed [W-1:0]          min_load_threshold,
  input  wire logic                         fast_detect,
  input  wire logic                         load_diff_peak,
  input  wire lhj_pkg::lhj_base_t           base_select,
  input  wire logic [lhj_pkg::POINTS-1:0]   offset_use,
  input  wire logic [lhj_pkg::POINTS*W-1:0] offset_length,
  input  wire logic [lhj_pkg::POINTS*W-1:0] offset_upper,
  input  wire logic [lhj_pkg::POINTS*W-1:0] offset_lower,
  input  wire logic [lhj_pkg::ZONES-1:0]    zone_select,
  input  wire logic [lhj_pkg::ZONES-1:0]    zone_ok,
  output logic                              upper_limit_judgment,
  output logic                              lower_limit_judgment,
  output logic                              upper_upper_judgment,
  output logic                              lower_lower_judgment,
  output logic                              both_high_low_result,
  output logic                              pass_judgment,
  output logic                              meas_completed,
  output logic                              judge_completed,
  output logic                              measuring
);
  localparam int DIV_W = $clog2(TICK_CYCLES + 1);
  localparam int TW    = lhj_pkg::TICK_W;
  localparam int DEPTH = lhj_pkg::MEAS_MAX_TICKS + 1;

  generate
    if (W < 4 || TICK_CYCLES < 1)
      $error("lhj_judge: W must be at least 4 and TICK_CYCLES at least 1");
  endgenerate

  typedef enum logic [2:0] {ST_IDLE, ST_MEASURE, ST_SCAN, ST_JUDGE, ST_DONE} lhj_state_t;

  typedef struct packed {
    lhj_state_t          st;
    logic                s1;
    logic                s2;
    logic                s_prev;
    logic [DIV_W-1:0]    div;
    logic [TW-1:0]       ticks;
    logic signed [W-1:0] held_load;
    logic signed [W-1:0] held_disp;
    logic signed [W-1:0] base_disp;
    logic signed [W-1:0] peak_disp;
    logic signed [W-1:0] tick_max;
    logic                infl_found;
    logic [TW-1:0]       infl_tick;
    logic signed [W-1:0] infl_load;
    logic [TW-1:0]       scan_idx;
    logic [TW-1:0]       scan_hi;
    logic                scan_any;
    logic signed [W-1:0] scan_peak;
    logic                hi;
    logic                lo;
    logic                hh;
    logic                ll;
    logic                pass;
    logic                hl;
    logic                meas_done;
    logic                judge_done;
    logic                busy;
  } lhj_judge_t;

  lhj_judge_t          q_ff;
  lhj_judge_t          nxt_q;
  logic signed [W-1:0] hist_ff [DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Shared signals
  logic                start_edge;
  logic                tick;
  logic                meas_end;
  logic [TW-1:0]       meas_lim;
  logic                infl_mode;
  logic                live;
  logic signed [W-1:0] jv;
  logic [3:0]          cmp_on;
  logic [3:0]          cmp_prev;
  logic signed [W-1:0] cmp_lim [4];
  logic [lhj_pkg::POINTS-1:0] pt_fail;
  logic [lhj_pkg::POINTS-1:0] pt_missing;
  logic [TW-1:0]       shifted;
  logic [TW-1:0]       win_lo;
  logic [TW-1:0]       floor_idx;
  logic [TW-1:0]       last_idx;

  assign start_edge = q_ff.s2 & ~q_ff.s_prev;
  assign tick       = (q_ff.div == DIV_W'(TICK_CYCLES - 1));
  assign meas_lim   = (meas_time > TW'(lhj_pkg::MEAS_MAX_TICKS)) ? TW'(lhj_pkg::MEAS_MAX_TICKS) : meas_time;
  assign meas_end   = (q_ff.st == ST_MEASURE) && (q_ff.ticks >= meas_lim);
  assign infl_mode  = (hold_mode == lhj_pkg::MODE_INFL);
  // Live judgment only for plain load hold; other modes judge held values only
  assign live       = (q_ff.st == ST_MEASURE) && continuous_judgment
                      && (criterion == lhj_pkg::CRIT_LOAD) && (hold_mode == lhj_pkg::MODE_PEAK);
  assign jv         = (q_ff.st == ST_MEASURE) ? meas_load : (infl_mode ? q_ff.scan_peak : q_ff.held_load);

  ////////////////////////////////////////////////////////////////////////////
  // Limit comparators: 0 upper-upper, 1 upper, 2 lower, 3 lower-lower
  assign cmp_lim[0] = upper_upper_limit;
  assign cmp_lim[1] = upper_limit;
  assign cmp_lim[2] = lower_limit;
  assign cmp_lim[3] = lower_lower_limit;
  assign cmp_prev   = {q_ff.ll, q_ff.lo, q_ff.hi, q_ff.hh};

  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_cmp
      lhj_limit_cmp #(
        .W     (W),
        .UPPER (i < 2)
      ) u_cmp (
        .value          (jv),
        .limit          (cmp_lim[i]),
        .hyst           (hysteresis_width),
        .hyst_en        ((hysteresis_width != '0) && continuous_judgment),
        .enable         ((i == 0) ? (upper_upper_enable && !infl_mode) :
                         (i == 3) ? (lower_lower_enable && !infl_mode) : 1'b1),
        .prev_on        (cmp_prev[i]),
        .override_clear ((i < 2) ? (jv < lower_limit) : (jv > upper_limit)),
        .on             (cmp_on[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Many-point hold positions
  generate
    for (genvar p = 0; p < lhj_pkg::POINTS; p++)
    begin : g_pt
      lhj_point_hold #(
        .W (W)
      ) u_pt (
        .clk        (clk),
        .rst_n      (rst_n),
        .clear      (start_edge),
        .run        ((q_ff.st == ST_MEASURE) && (hold_mode == lhj_pkg::MODE_MANY)),
        .use_point  (offset_use[p]),
        .base_sel   (base_select),
        .base_disp  (q_ff.base_disp),
        .peak_disp  (q_ff.peak_disp),
        .disp       (meas_disp),
        .load       (meas_load),
        .offset_len (offset_length[p*W +: W]),
        .up_lim     (offset_upper[p*W +: W]),
        .lo_lim     (offset_lower[p*W +: W]),
        .fail       (pt_fail[p]),
        .missing    (pt_missing[p])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Peak window ending at the shifted inflection point
  always_comb
  begin
    shifted   = (q_ff.infl_tick > TW'(inflection_shift)) ? q_ff.infl_tick - TW'(inflection_shift) : '0;
    win_lo    = (shifted > TW'(peak_range)) ? shifted - TW'(peak_range) : '0;
    floor_idx = TW'(analysis_offset) + TW'(peak_inhibit);
    if (floor_idx > win_lo)
      win_lo = floor_idx;
    last_idx  = q_ff.ticks - TW'(1);
    if (shifted < last_idx)
      last_idx = shifted;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    nxt_q        = q_ff;
    nxt_q.s1     = meas_start;
    nxt_q.s2     = q_ff.s1;
    nxt_q.s_prev = q_ff.s2;

    case (q_ff.st)
      ST_MEASURE:
      begin
        nxt_q.div = tick ? '0 : q_ff.div + DIV_W'(1);
        if (tick)
        begin
          nxt_q.ticks    = q_ff.ticks + TW'(1);
          nxt_q.tick_max = meas_load;
        end
        else if (meas_load > q_ff.tick_max)
          nxt_q.tick_max = meas_load;
        if (meas_load > q_ff.held_load)
          nxt_q.held_load = meas_load;
        if (meas_disp > q_ff.held_disp)
          nxt_q.held_disp = meas_disp;
        if (meas_disp > q_ff.peak_disp)
          nxt_q.peak_disp = meas_disp;
        // Inflection search opens after the analysis offset
        if (infl_mode && !q_ff.infl_found && (q_ff.ticks >= TW'(analysis_offset))
            && (fast_detect ? load_diff_peak : (meas_load >= analysis_start_level)))
        begin
          nxt_q.infl_found = 1'b1;
          nxt_q.infl_tick  = q_ff.ticks;
          nxt_q.infl_load  = meas_load;
        end
        if (live)
        begin
          nxt_q.hh = cmp_on[0];
          nxt_q.hi = cmp_on[1];
          nxt_q.lo = cmp_on[2];
          nxt_q.ll = cmp_on[3];
        end
        if (meas_end)
        begin
          nxt_q.meas_done = 1'b1;
          nxt_q.busy      = 1'b0;
          nxt_q.scan_peak = q_ff.infl_load;
          nxt_q.scan_any  = 1'b0;
          nxt_q.scan_idx  = win_lo;
          nxt_q.scan_hi   = last_idx;
          // Empty window falls back to the load at the inflection point
          if (infl_mode && q_ff.infl_found && (q_ff.ticks != '0) && (win_lo <= last_idx))
            nxt_q.st = ST_SCAN;
          else
            nxt_q.st = ST_JUDGE;
        end
      end

      ST_SCAN:
      begin
        // One entry per cycle: at most 300 cycles, far inside the 1 ms budget
        if (!q_ff.scan_any || (hist_ff[q_ff.scan_idx] > q_ff.scan_peak))
          nxt_q.scan_peak = hist_ff[q_ff.scan_idx];
        nxt_q.scan_any = 1'b1;
        nxt_q.scan_idx = q_ff.scan_idx + TW'(1);
        if (q_ff.scan_idx >= q_ff.scan_hi)
          nxt_q.st = ST_JUDGE;
      end

      ST_JUDGE:
      begin
        nxt_q.hh   = 1'b0;
        nxt_q.hi   = 1'b0;
        nxt_q.lo   = 1'b0;
        nxt_q.ll   = 1'b0;
        nxt_q.pass = 1'b0;
        case (criterion)
          lhj_pkg::CRIT_LOAD:
          begin
            if (hold_mode == lhj_pkg::MODE_MANY)
            begin
              nxt_q.hi = |pt_fail;
              nxt_q.lo = |pt_fail;
              nxt_q.ll = |pt_missing;
            end
            else if (infl_mode && (!q_ff.infl_found || (q_ff.infl_load < min_load_threshold)))
            begin
              nxt_q.hi = 1'b1;
              nxt_q.lo = 1'b1;
            end
            else
            begin
              nxt_q.hh = cmp_on[0];
              nxt_q.hi = cmp_on[1];
              nxt_q.lo = cmp_on[2];
              nxt_q.ll = cmp_on[3];
            end
          end
          lhj_pkg::CRIT_DISP:
          begin
            nxt_q.hi = q_ff.held_disp > disp_upper_limit;
            nxt_q.lo = q_ff.held_disp < disp_lower_limit;
          end
          lhj_pkg::CRIT_ZONE_TIME, lhj_pkg::CRIT_ZONE_DISP:
            nxt_q.pass = (|zone_select) && (&(zone_ok | ~zone_select));
          default:
            nxt_q.pass = 1'b0;
        endcase
        nxt_q.judge_done = 1'b1;
        nxt_q.st         = ST_DONE;
      end

      ST_IDLE, ST_DONE:
        nxt_q.st = q_ff.st;

      default:
        nxt_q.st = ST_IDLE;
    endcase

    // Combined result and pass after the per-limit flags are settled
    if (q_ff.st == ST_JUDGE)
    begin
      nxt_q.hl = nxt_q.hi & nxt_q.lo;
      if ((criterion == lhj_pkg::CRIT_LOAD) || (criterion == lhj_pkg::CRIT_DISP))
        nxt_q.pass = ~(nxt_q.hi | nxt_q.lo | nxt_q.hh | nxt_q.ll);
    end

    // A start edge wins over everything and restarts the measurement
    if (start_edge)
    begin
      nxt_q.st         = ST_MEASURE;
      nxt_q.busy       = 1'b1;
      nxt_q.div        = '0;
      nxt_q.ticks      = '0;
      nxt_q.held_load  = meas_load;
      nxt_q.held_disp  = meas_disp;
      nxt_q.base_disp  = meas_disp;
      nxt_q.peak_disp  = meas_disp;
      nxt_q.tick_max   = meas_load;
      nxt_q.infl_found = 1'b0;
      nxt_q.infl_tick  = '0;
      nxt_q.infl_load  = '0;
      nxt_q.hh         = 1'b0;
      nxt_q.hi         = 1'b0;
      nxt_q.lo         = 1'b0;
      nxt_q.ll         = 1'b0;
      nxt_q.hl         = 1'b0;
      nxt_q.pass       = 1'b0;
      nxt_q.meas_done  = 1'b0;
      nxt_q.judge_done = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q_ff    <= '0;
      q_ff.st <= ST_IDLE;
    end
    else
      q_ff <= nxt_q;
  end

  // Per-tick load maximum, read back by the peak window scan
  always_ff @(posedge clk)
  begin
    if ((q_ff.st == ST_MEASURE) && tick && (q_ff.ticks < TW'(DEPTH)))
      hist_ff[q_ff.ticks] <= q_ff.tick_max;
  end

  assign upper_limit_judgment = q_ff.hi;
  assign lower_limit_judgment = q_ff.lo;
  assign upper_upper_judgment = q_ff.hh;
  assign lower_lower_judgment = q_ff.ll;
  assign both_high_low_result = q_ff.hl;
  assign pass_judgment        = q_ff.pass;
  assign meas_completed       = q_ff.meas_done;
  assign judge_completed      = q_ff.judge_done;
  assign measuring            = q_ff.busy;
endmodule // lhj_judge
`default_nettype wire

// *** rtl/lhj_pkg.sv ***
// Constants, enumerations and timing figures shared by the load-hold judgment block
//
// Functional notes
// - Upper or upper-upper judgment on when value is strictly above that limit.
// - Lower or lower-lower judgment on when value is strictly below that limit.
// - Hysteresis works only with a nonzero width; zero gives plain comparison.
// - Upper judgment holds until load falls below upper limit minus width.
// - Lower judgment holds until load rises above lower limit plus width.
// - One width serves all four limits; outer judgments release the same way.
// - Plain opposite-limit result overrides a hysteresis-extended judgment.
// - Hysteresis applies only while continuous judgment is enabled.
// - Upper-upper and lower-lower limits can each be disabled, never judging; in many-point hold the lower-lower judgment still flags missing points.
// - Inflection-trigger peak hold ignores outer limits, judging upper and lower.
// - Inflection load below minimum-load threshold gives combined high-low result.
// - Inflection point shifted earlier by offset; peak window computed from there.
// - Fast detect off judges at start level; on uses load-difference peak.
// - Many-point hold keeps load at up to five offsets, each own limits.
// - Many-point base is displacement at start or the peak displacement.
// - Five offsets, individually selectable, each with own length from base.
// - Criterion is none, load, displacement, or time or displacement zones.
// - Zone pass only when every selected zone, at most three, is acceptable.
// - Within 1 ms of start, release holds and clear judgments and completion.
// - Within 1 ms of measurement end, judgments valid with judgment-completed.
// - Measuring period follows configured time, never above 30.0 seconds.
// - Analysis offset, peak range and inhibit each span zero to 9.9 seconds; the 7-bit inputs are not clamped and reach 12.7 seconds.
package lhj_pkg;

  typedef enum logic [1:0] {MODE_PEAK, MODE_INFL, MODE_MANY} lhj_mode_t;
  typedef enum logic [2:0] {CRIT_NONE, CRIT_LOAD, CRIT_DISP, CRIT_ZONE_TIME, CRIT_ZONE_DISP} lhj_crit_t;
  typedef enum logic {BASE_BEGIN, BASE_PEAK} lhj_base_t;

  localparam int CLK_PERIOD_PS    = 4000;
  localparam int TICK_TIME_MS     = 100;
  localparam int TICK_CYC         = TICK_TIME_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int RESPONSE_MAX_MS  = 1;
  localparam int MEAS_MAX_TICKS   = 300;
  localparam int ANA_MAX_TICKS    = 99;
  localparam int TICK_W           = 9;
  localparam int ANA_W            = 7;
  localparam int POINTS           = 5;
  localparam int ZONES            = 3;

endpackage

// *** rtl/lhj_limit_cmp.sv ***
// One limit comparator with optional hysteresis release
`timescale 1ns/100ps
`default_nettype none
module lhj_limit_cmp #(
  parameter int W     = 24,
  parameter bit UPPER = 1'b1
) (
  input  wire logic signed [W-1:0] value,
  input  wire logic signed [W-1:0] limit,
  input  wire logic signed [W-1:0] hyst,
  input  wire logic                hyst_en,
  input  wire logic                enable,
  input  wire logic                prev_on,
  input  wire logic                override_clear,
  output logic                     on
);
  logic signed [W:0] band;
  logic              plain;
  logic              keep;

  always_comb
  begin
    band  = UPPER ? (W+1)'(limit) - (W+1)'(hyst) : (W+1)'(limit) + (W+1)'(hyst);
    plain = UPPER ? (value > limit) : (value < limit);
    keep  = UPPER ? ((W+1)'(value) >= band) : ((W+1)'(value) <= band);
    on    = enable & (plain | (hyst_en & prev_on & keep & ~override_clear));
  end
endmodule // lhj_limit_cmp
`default_nettype wire

// *** rtl/lhj_point_hold.sv ***
// One many-point hold position: captures load at its displacement offset and judges it
`timescale 1ns/100ps
`default_nettype none
module lhj_point_hold #(
  parameter int W = 24
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                clear,
  input  wire logic                run,
  input  wire logic                use_point,
  input  wire lhj_pkg::lhj_base_t  base_sel,
  input  wire logic signed [W-1:0] base_disp,
  input  wire logic signed [W-1:0] peak_disp,
  input  wire logic signed [W-1:0] disp,
  input  wire logic signed [W-1:0] load,
  input  wire logic signed [W-1:0] offset_len,
  input  wire logic signed [W-1:0] up_lim,
  input  wire logic signed [W-1:0] lo_lim,
  output logic                     fail,
  output logic                     missing
);
  typedef struct packed {
    logic                captured;
    logic signed [W-1:0] held;
  } lhj_point_t;

  lhj_point_t q_ff;
  lhj_point_t nxt_q;
  logic       reach;

  always_comb
  begin
    nxt_q = q_ff;
    // Peak base: the point is passed on the way back from the displacement peak
    if (base_sel == lhj_pkg::BASE_BEGIN)
      reach = ((W+1)'(disp) - (W+1)'(base_disp)) >= (W+1)'(offset_len);
    else
      reach = ((W+1)'(peak_disp) - (W+1)'(disp)) >= (W+1)'(offset_len)
              && ((W+1)'(peak_disp) - (W+1)'(base_disp)) >= (W+1)'(offset_len);
    if (clear)
      nxt_q = '0;
    else if (run && use_point && !q_ff.captured && reach)
    begin
      nxt_q.captured = 1'b1;
      nxt_q.held     = load;
    end
    fail    = use_point & q_ff.captured & ((q_ff.held > up_lim) | (q_ff.held < lo_lim));
    missing = use_point & ~q_ff.captured;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end
endmodule // lhj_point_hold
`default_nettype wire

// *** sim/lhj_ctrl_model.sv ***
// Machine controller model: raises the start input when asked to
`timescale 1ns/100ps
`default_nettype none
module lhj_ctrl_model (
  input  wire logic clk,
  input  wire logic go,
  output logic      meas_start
);
  int n = 0;
  // High three cycles, then low at least four, so the synchroniser never misses an edge
  always @(posedge clk)
  begin
    if (go && n == 0)
      n <= #1 6;
    else if (n > 0)
      n <= #1 n - 1;
  end
  assign meas_start = (n > 3);
endmodule // lhj_ctrl_model
`default_nettype wire

// *** sim/lhj_judge_chk.sv ***
// Port checker for the load-hold judgment block
`timescale 1ns/100ps
`default_nettype none
module lhj_judge_chk (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               meas_start,
  input wire lhj_pkg::lhj_mode_t hold_mode,
  input wire logic               upper_upper_enable,
  input wire logic               upper_limit_judgment,
  input wire logic               lower_limit_judgment,
  input wire logic               upper_upper_judgment,
  input wire logic               lower_lower_judgment,
  input wire logic               both_high_low_result,
  input wire logic               meas_completed,
  input wire logic               judge_completed,
  input wire logic               measuring
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Two synchroniser flops and the state register itself put three sampled edges between pin and measuring
  property p_start; $rose(meas_start) |-> ##3 measuring; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_clear; $rose(measuring) |-> !(meas_completed || judge_completed || upper_limit_judgment); endproperty
  a_clear: assert property (p_clear) else $error("stale result at start");
  property p_end; $fell(measuring) |-> meas_completed; endproperty
  a_end: assert property (p_end) else $error("end without completion");
  property p_judge; $rose(meas_completed) && hold_mode != lhj_pkg::MODE_INFL |=> judge_completed; endproperty
  a_judge: assert property (p_judge) else $error("late judgment");
  property p_stand; judge_completed |=> judge_completed || $rose(measuring); endproperty
  a_stand: assert property (p_stand) else $error("completion dropped");
  property p_hh_off; $rose(judge_completed) && !upper_upper_enable |-> !upper_upper_judgment; endproperty
  a_hh_off: assert property (p_hh_off) else $error("outer limit judged while off");
  property p_infl;
    $rose(judge_completed) && hold_mode == lhj_pkg::MODE_INFL |-> !(upper_upper_judgment || lower_lower_judgment);
  endproperty
  a_infl: assert property (p_infl) else $error("outer judgment in trigger mode");
  property p_hl; both_high_low_result |-> upper_limit_judgment && lower_limit_judgment; endproperty
  a_hl: assert property (p_hl) else $error("combined result alone");
  c_infl: cover property ($rose(judge_completed) && hold_mode == lhj_pkg::MODE_INFL);
  c_hl: cover property ($rose(both_high_low_result));
  c_restart: cover property ($rose(measuring) && $past(judge_completed));
endmodule // lhj_judge_chk
bind lhj_judge lhj_judge_chk u_chk (.*);
`default_nettype wire

// *** sim/tb_lhj_judge.sv ***
// Self-checking testbench for the load-hold judgment block
`timescale 1ns/100ps
`default_nettype none
module tb_lhj_judge;
  logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, meas_start, continuous_judgment = 1'b0;
  logic fast_detect = 1'b0, load_diff_peak = 1'b0, upper_upper_enable = 1'b1, lower_lower_enable = 1'b1;
  logic signed [23:0] meas_load = 24'sh0, meas_disp = 24'sh0, hysteresis_width = 24'sh0;
  logic signed [23:0] upper_limit = 24'sh64, lower_limit = -24'sh64; // Kept in order
  logic signed [23:0] upper_upper_limit = 24'shc8, lower_lower_limit = -24'shc8;
  logic signed [23:0] analysis_start_level = 24'sh32, min_load_threshold = 24'sh12c;
  logic [6:0] analysis_offset = 7'h0;
  logic [8:0] meas_time = 9'h3;
  logic [4:0] offset_use = 5'h01;
  logic [119:0] offset_length = 120'h64;
  logic [2:0] zone_select = 3'h3, zone_ok = 3'h3;
  lhj_pkg::lhj_mode_t hold_mode = lhj_pkg::MODE_PEAK;
  lhj_pkg::lhj_crit_t criterion = lhj_pkg::CRIT_LOAD;
  lhj_pkg::lhj_base_t base_select = lhj_pkg::BASE_BEGIN;
  logic upper_limit_judgment, lower_limit_judgment, upper_upper_judgment, lower_lower_judgment;
  logic both_high_low_result, pass_judgment, meas_completed, judge_completed, measuring;
  int err_count = 0, n_compared = 0, k;
  lhj_judge #(.TICK_CYCLES(2)) dut (.*, .disp_upper_limit(upper_limit), .disp_lower_limit(lower_limit),
    .peak_range(analysis_offset), .peak_inhibit(analysis_offset), .inflection_shift(analysis_offset),
    .offset_upper(offset_length), .offset_lower(offset_length));
  lhj_ctrl_model ctrl (.clk(clk), .go(go), .meas_start(meas_start));
  always #2 clk = ~clk;
  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic judged(input logic [5:0] x);
    for (k = 0; k < 99 && judge_completed !== 1'b1; k++) @(negedge clk);
    check({measuring, judge_completed, upper_upper_judgment, upper_limit_judgment, lower_limit_judgment,
      lower_lower_judgment, both_high_low_result, pass_judgment}, {2'b01, x});
    @(posedge clk);
    #1;
  endtask
  // Returns in the first measuring cycle, so each following step lands on a live judgment edge
  task automatic start_live(input logic signed [23:0] h, input logic c);
    hysteresis_width = h;
    continuous_judgment = c;
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic step(input logic signed [23:0] l, input logic [1:0] e);
    meas_load = l;
    @(posedge clk);
    #1 check({6'h0, upper_limit_judgment, lower_limit_judgment}, {6'h0, e});
  endtask
  // Point 0 sits beyond any displacement reached, so many-point mode reports it missing
  task automatic run(input logic signed [23:0] l, input logic [5:0] x);
    meas_load = l;
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    for (k = 0; k < 20 && measuring !== 1'b1; k++) @(negedge clk);
    check({6'h0, meas_completed, judge_completed}, 8'h0);
    judged(x);
  endtask
  task automatic end_of_test;
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #40000;
    err_count++;
    end_of_test;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    run(24'sh64, 6'h01);
    run(24'sh65, 6'h10);
    run(24'shc9, 6'h30);
    run(-24'sh65, 6'h08);
    run(-24'shc9, 6'h0c);
    upper_upper_enable = 1'b0;
    run(24'shc9, 6'h10);
    upper_upper_enable = 1'b1;
    criterion = lhj_pkg::CRIT_NONE;
    run(24'shc9, 6'h00);
    criterion = lhj_pkg::CRIT_DISP;
    run(24'shc9, 6'h01);
    criterion = lhj_pkg::CRIT_ZONE_TIME;
    run(24'sh0, 6'h01);
    zone_ok = 3'h1;
    run(24'sh0, 6'h00);
    criterion = lhj_pkg::CRIT_LOAD;
    hold_mode = lhj_pkg::MODE_INFL;
    run(24'shfa, 6'h1a);
    min_load_threshold = 24'shc8;
    run(24'shfa, 6'h10);
    hold_mode = lhj_pkg::MODE_MANY;
    run(24'sh0, 6'h04);
    hold_mode = lhj_pkg::MODE_PEAK;
    start_live(24'sh14, 1'b1);
    step(24'sh65, 2'h2);
    step(24'sh5a, 2'h2);
    step(24'sh46, 2'h0);
    step(-24'sh65, 2'h1);
    step(-24'sh5a, 2'h1);
    step(-24'sh46, 2'h0);
    judged(6'h10);
    // Band of the upper limit reaches below the lower limit here
    start_live(24'shfa, 1'b1);
    step(24'sh65, 2'h2);
    step(-24'sh65, 2'h1);
    judged(6'h10);
    start_live(24'sh14, 1'b0);
    step(24'sh65, 2'h0);
    judged(6'h10);
    end_of_test;
  end
endmodule // tb_lhj_judge
`default_nettype wire
